// ==== dfc_apb_regs.sv ====
// Purpose: APB slave holding the compensation settings
// Assumes: Zero wait state after the setup cycle
// Notes: Unmapped addresses answer with pslverr and read zero
`timescale 1ns/10ps
module dfc_apb_regs (
  input wire logic clk_sys,                  // System clock
  input wire logic srst,                     // Synchronous reset
  input wire logic psel,                     // APB select
  input wire logic penable,                  // APB enable
  input wire logic pwrite,                   // APB direction
  input wire logic [15:0] paddr,             // APB byte address
  input wire logic [31:0] pwdata,            // APB write data
  output logic [31:0] prdata,                // APB read data
  output logic pready,                       // APB ready
  output logic pslverr,                      // APB error
  output dfc_pkg::dfc_cfg_t cfg,             // Settings to the datapath
  input wire logic [15:0] status             // Live status
);
  import dfc_pkg::*;
  // ****************************************
  // Decode
  // ****************************************
  logic setup; // First cycle of a transfer
  logic wr_go; // Write commits this edge
  logic mapped; // Address names a register
  logic [15:0] rd_d; // Read value chosen in setup
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pready & pwrite;
  always_comb begin
    mapped = 1'b1;
    rd_d = 16'h0000;
    if (dfc_hit(paddr, DFC_IDX_TUNE)) rd_d = cfg.tune;
    else if (dfc_hit(paddr, DFC_IDX_UNBAL)) rd_d = cfg.unbal;
    else if (dfc_hit(paddr, DFC_IDX_POSF)) rd_d = cfg.posf;
    else if (dfc_hit(paddr, DFC_IDX_NEGF)) rd_d = cfg.negf;
    else if (dfc_hit(paddr, DFC_IDX_FX)) rd_d = cfg.fx;
    else if (dfc_hit(paddr, DFC_IDX_GAIN)) rd_d = cfg.gain;
    else if (dfc_hit(paddr, DFC_IDX_FILT)) rd_d = cfg.filt;
    else if (dfc_hit(paddr, DFC_IDX_STAT)) rd_d = status;
    else mapped = 1'b0;
  end
  // Answer is prepared in setup so pready and data come from flops
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? {16'h0000, rd_d} : 32'h0000_0000;
    end
  end
  // Writes land at the access edge; status is read only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg <= {7{DFC_REG_RST}};
    end else if (wr_go) begin
      if (dfc_hit(paddr, DFC_IDX_TUNE)) cfg.tune <= pwdata[15:0];
      if (dfc_hit(paddr, DFC_IDX_UNBAL)) cfg.unbal <= pwdata[15:0];
      if (dfc_hit(paddr, DFC_IDX_POSF)) cfg.posf <= pwdata[15:0];
      if (dfc_hit(paddr, DFC_IDX_NEGF)) cfg.negf <= pwdata[15:0];
      if (dfc_hit(paddr, DFC_IDX_FX)) cfg.fx <= pwdata[15:0];
      if (dfc_hit(paddr, DFC_IDX_GAIN)) cfg.gain <= pwdata[15:0];
      if (dfc_hit(paddr, DFC_IDX_FILT)) cfg.filt <= pwdata[15:0];
    end
  end
endmodule // dfc_apb_regs

// ==== dfc_checker.sv ====
// Purpose: Port-level assertions for the compensation stage
// Assumes: Bound onto dfc_comp_top, one clock domain
// Notes: Register contents are hidden, so checks tie outputs to mode and servo
`timescale 1ns/10ps
module dfc_checker (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic ctrl_ce, // Control-cycle pulse
  input dfc_pkg::dfc_drive_t drive_st, // Mode and servo state
  input wire logic pcmd_valid, // Position command present
  input wire logic signed [15:0] force_in, // Force command in
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic signed [15:0] force_out, // Compensated force
  input wire logic signed [15:0] unbal_comp, // Unbalanced-load term
  input wire logic signed [15:0] fric_comp, // Friction term
  input wire logic dob_active // Observer running
);
  import dfc_pkg::*;
  // ************
  // Helpers
  // ************
  logic signed [17:0] sum_w; // Wide sum, so an overflow is seen and skipped
  logic dob_ok_w; // Mode and servo allow the observer
  assign sum_w = 18'(force_in) + 18'(unbal_comp) + 18'(fric_comp);
  assign dob_ok_w = drive_st.servo_on && !drive_st.pole_est_busy &&
    (drive_st.mode == DFC_MODE_POS || drive_st.mode == DFC_MODE_SPD);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ************
  // Assertions
  // ************
  a_force_zero: assert property (
    ctrl_ce && drive_st.mode == DFC_MODE_FRC |=> unbal_comp == 16'sh0 && fric_comp == 16'sh0)
    else $error("offsets not zero in force control");
  a_spd_fric: assert property (
    ctrl_ce && drive_st.mode == DFC_MODE_SPD |=> fric_comp == 16'sh0)
    else $error("friction term not zero in speed control");
  a_dob_gate: assert property (
    !dob_ok_w |=> !dob_active)
    else $error("observer active while mode or servo forbid it");
  a_hold_cmd: assert property (
    (drive_st.mode == DFC_MODE_POS && !pcmd_valid) ##1 drive_st.mode == DFC_MODE_POS
    |-> $stable(unbal_comp) && $stable(fric_comp))
    else $error("offsets moved without a position command");
  a_out_sum: assert property (
    !dob_active [*3] ##0 (ctrl_ce && sum_w > -18'sd32768 && sum_w < 18'sd32767)
    |=> force_out == $past(sum_w[15:0]))
    else $error("force output not the plain sum with observer off");
  a_out_hold: assert property (
    !ctrl_ce |=> $stable(force_out))
    else $error("force output moved between control cycles");
  a_apb_ready: assert property (
    psel && !penable |=> pready)
    else $error("no ready in the access cycle");
  a_apb_quiet: assert property (
    !psel |=> !pready)
    else $error("ready without a transfer");
  c_force: cover property (ctrl_ce && drive_st.mode == DFC_MODE_FRC);
  c_dob: cover property ($rose(dob_active));
  c_cmd: cover property (pcmd_valid && drive_st.mode == DFC_MODE_POS);
endmodule // dfc_checker
bind dfc_comp_top dfc_checker i_dfc_checker (.clk_sys(clk_sys), .srst(srst), .ctrl_ce(ctrl_ce),
  .drive_st(drive_st), .pcmd_valid(pcmd_valid), .force_in(force_in), .psel(psel), .penable(penable),
  .pready(pready), .force_out(force_out), .unbal_comp(unbal_comp), .fric_comp(fric_comp),
  .dob_active(dob_active));

// ==== dfc_comp_top.sv ====
// Purpose: Force-command compensation stage: disturbance observer and friction offsets
// Assumes: Inputs are synchronous to clk_sys; ctrl_ce marks the control cycle
// Notes: Output updates once per control cycle, one cycle after ctrl_ce
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module dfc_comp_top (
  input wire logic clk_sys,                  // System clock, 100 MHz
  input wire logic srst,                     // Synchronous reset, high
  input wire logic ctrl_ce,                  // Control-cycle enable pulse
  input dfc_pkg::dfc_drive_t drive_st,       // Mode and servo state
  input wire logic pcmd_valid,               // Position command this cycle
  input wire logic signed [31:0] pcmd_delta, // Position command amount
  input wire logic signed [15:0] force_in,   // Force command before compensation
  input wire logic signed [15:0] dist_est,   // Raw disturbance estimate
  input wire logic psel,                     // APB select
  input wire logic penable,                  // APB enable
  input wire logic pwrite,                   // APB direction
  input wire logic [15:0] paddr,             // APB byte address
  input wire logic [31:0] pwdata,            // APB write data
  output logic [31:0] prdata,                // APB read data
  output logic pready,                       // APB ready
  output logic pslverr,                      // APB error
  output logic signed [15:0] force_out,      // Compensated force command
  output logic signed [15:0] unbal_comp,     // Unbalanced-load term in use
  output logic signed [15:0] fric_comp,      // Friction term in use
  output logic dob_active                    // Observer running
);
  import dfc_pkg::*;

  // ****************************************
  // Settings
  // ****************************************
  dfc_cfg_t cfg; // Registers from the bus slave
  logic [15:0] status; // Live status word
  logic dob_apply; // Observer output allowed
  logic signed [15:0] dob_comp; // Filtered, scaled estimate

  // Bus slave holds every setting
  dfc_apb_regs u_regs (
    .clk_sys(clk_sys),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg),
    .status(status)
  );

  // ****************************************
  // Observer gating
  // ****************************************
  logic mode_ok; // Position or speed control
  logic dob_d; // Next observer state
  logic dob_q; // Observer running

  // Mode decode; unused code counts as not allowed
  always_comb begin
    unique case (drive_st.mode)
      DFC_MODE_POS: mode_ok = 1'b1;
      DFC_MODE_SPD: mode_ok = 1'b1;
      DFC_MODE_FRC: mode_ok = 1'b0;
      default: mode_ok = 1'b0;
    endcase
  end

  // All conditions must hold at once
  always_comb begin
    dob_d = mode_ok & drive_st.servo_on;
    dob_d = dob_d & (cfg.tune == 16'h0000);
    dob_d = dob_d & ~cfg.fx[DFC_FX_ISO];
    dob_d = dob_d & ~drive_st.pole_est_busy;
    dob_d = dob_d & cfg.fx[DFC_FX_DOB_EN];
  end

  // Registered so the filter sees one clean level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dob_q <= 1'b0;
    end else begin
      dob_q <= dob_d;
    end
  end

  // Gain-set restriction only when bit two is set
  assign dob_apply = ~cfg.fx[DFC_FX_G1_ONLY] | drive_st.gain1_sel;

  // Lag filter and gain stage
  dfc_dob_filter u_filt (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ctrl_ce),
    .active(dob_q),
    .apply(dob_apply),
    .est_in(dist_est),
    .filt_time(cfg.filt),
    .gain(cfg.gain),
    .comp(dob_comp)
  );

  // ****************************************
  // Position command tracking
  // ****************************************
  dfc_pc_t pc_q; // Command tracking state
  dfc_pc_t pc_d; // Next tracking state
  logic servo_q; // Servo state last cycle
  logic servo_rise; // Servo just turned on
  logic pcmd_nz; // Non-zero command present
  logic in_pos; // Position control now

  assign in_pos = (drive_st.mode == DFC_MODE_POS);
  assign servo_rise = drive_st.servo_on & ~servo_q;
  // A zero command carries no direction
  assign pcmd_nz = pcmd_valid & (pcmd_delta != 32'sh0000_0000);

  // Edge detect on servo state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      servo_q <= 1'b0;
    end else begin
      servo_q <= drive_st.servo_on;
    end
  end

  // Hold from servo-on until the first command in position control
  always_comb begin
    pc_d = pc_q;
    unique case (pc_q)
      DFC_PC_IDLE: begin
        if (in_pos && servo_rise) pc_d = DFC_PC_HOLD;
        else if (in_pos && pcmd_nz) pc_d = DFC_PC_RUN;
      end
      DFC_PC_HOLD: begin
        if (!in_pos || !drive_st.servo_on) pc_d = DFC_PC_IDLE;
        else if (pcmd_nz) pc_d = DFC_PC_RUN;
      end
      DFC_PC_RUN: begin
        if (!in_pos) pc_d = DFC_PC_IDLE;
        else if (servo_rise) pc_d = DFC_PC_HOLD;
      end
      default: pc_d = DFC_PC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_q <= DFC_PC_IDLE;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ****************************************
  // Friction compensation
  // ****************************************
  logic signed [15:0] unbal_d; // Next unbalanced term
  logic signed [15:0] fric_d; // Next friction term

  // Mode decides what each term becomes; position mode only moves on a command
  always_comb begin
    unbal_d = unbal_comp;
    fric_d = fric_comp;
    unique case (drive_st.mode)
      DFC_MODE_FRC: begin
        unbal_d = 16'sh0000;
        fric_d = 16'sh0000;
      end
      DFC_MODE_SPD: begin
        unbal_d = $signed(cfg.unbal);
        fric_d = 16'sh0000;
      end
      DFC_MODE_POS: begin
        // Between commands the last values stand; during hold nothing moves
        if (pcmd_nz) begin
          unbal_d = $signed(cfg.unbal);
          if (!pcmd_delta[31]) fric_d = $signed(cfg.posf);
          else fric_d = $signed(cfg.negf);
        end
      end
      default: begin
        unbal_d = $signed(cfg.unbal);
        fric_d = 16'sh0000;
      end
    endcase
  end

  // Commands may arrive between control cycles, so position updates are not gated
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      unbal_comp <= 16'sh0000;
      fric_comp <= 16'sh0000;
    end else if (ctrl_ce || pcmd_nz) begin
      unbal_comp <= unbal_d;
      fric_comp <= fric_d;
    end
  end

  // ****************************************
  // Output sum
  // ****************************************
  logic signed [35:0] sum; // Wide sum, no wrap

  // Observer term is already zero when inactive
  assign sum = 36'(force_in) + 36'(unbal_comp) + 36'(fric_comp) - 36'(dob_comp);

  // Saturating output, refreshed each control cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      force_out <= 16'sh0000;
    end else if (ctrl_ce) begin
      force_out <= dfc_sat(sum);
    end
  end

  // Observer flag is a second flop of dob_d, in step with dob_q
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dob_active <= 1'b0;
    end else begin
      dob_active <= dob_d;
    end
  end

  // ****************************************
  // Status
  // ****************************************
  // Software sees gating and hold state without touching the datapath
  always_comb begin
    status = 16'h0000;
    status[DFC_ST_DOB] = dob_q;
    status[DFC_ST_HOLD] = (pc_q == DFC_PC_HOLD);
    status[DFC_ST_APPLY] = dob_q & dob_apply;
  end
endmodule // dfc_comp_top

// ==== dfc_dob_filter.sv ====
// Purpose: Lag filter and gain for the disturbance force estimate
// Assumes: ce is one cycle per control cycle
// Notes: Filter shift is the bit length of the time setting, capped at 15
`timescale 1ns/10ps
module dfc_dob_filter (
  input wire logic clk_sys,                  // System clock
  input wire logic srst,                     // Synchronous reset
  input wire logic ce,                       // Control-cycle enable
  input wire logic active,                   // Observer running
  input wire logic apply,                    // Output may be applied
  input wire logic signed [15:0] est_in,     // Raw disturbance estimate
  input wire logic [15:0] filt_time,         // Filter time setting
  input wire logic [15:0] gain,              // Gain setting
  output logic signed [15:0] comp            // Scaled compensation
);
  import dfc_pkg::*;
  logic signed [31:0] acc_q; // Filter state, 16 fraction bits
  logic signed [31:0] diff; // Input minus state
  logic [3:0] shift; // Lag strength
  logic signed [33:0] prod; // Filtered times gain
  // Bit length of the setting; smaller setting, less lag
  always_comb begin
    shift = 4'd0;
    for (int i = 0; i < 16; i++) begin
      if (filt_time[i]) shift = (i > 14) ? 4'd15 : 4'(i + 1);
    end
  end
  assign diff = 32'(({{16{est_in[15]}}, est_in} <<< DFC_ACC_FRAC) - acc_q);
  // Filter runs only while active and restarts from zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_q <= 32'sh0000_0000;
    end else if (!active) begin
      acc_q <= 32'sh0000_0000;
    end else if (ce) begin
      acc_q <= acc_q + (diff >>> shift);
    end
  end
  // Integer part taken as signed, so a negative estimate keeps its sign through the gain
  assign prod = 34'($signed(acc_q[31:16]) * $signed({1'b0, gain}));
  // Gain scaling; zero unless running and allowed to apply
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      comp <= 16'sh0000;
    end else if (!(active && apply)) begin
      comp <= 16'sh0000;
    end else if (ce) begin
      comp <= dfc_sat(36'(prod >>> DFC_GAIN_FRAC));
    end
  end
endmodule // dfc_dob_filter

// ==== dfc_host_model.sv ====
// Purpose: Host stand-in: control-cycle pulse and position commands
// Assumes: The bench asks for a command with a one-cycle request
// Notes: Amount is scrambled when idle so a stale value is never trusted
`timescale 1ns/10ps
module dfc_host_model #(
  parameter int CE_DIV = 4 // Clocks per control cycle, short for simulation
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic cmd_req, // Bench asks for one command
  input wire logic signed [31:0] cmd_amt, // Amount to send
  output logic ctrl_ce, // Control-cycle pulse
  output logic pcmd_valid, // Position command present
  output logic signed [31:0] pcmd_delta // Position command amount
);
  logic [7:0] div_q; // Control-cycle divider
  // Divider: one pulse every CE_DIV clocks
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_q <= 8'h00;
      ctrl_ce <= 1'b0;
    end else begin
      div_q <= (div_q == 8'(CE_DIV - 1)) ? 8'h00 : div_q + 8'h01;
      ctrl_ce <= (div_q == 8'(CE_DIV - 1));
    end
  end
  // Command: one cycle, amount inverted between commands
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pcmd_valid <= 1'b0;
      pcmd_delta <= 32'sh0;
    end else begin
      pcmd_valid <= cmd_req;
      pcmd_delta <= cmd_req ? cmd_amt : ~pcmd_delta;
    end
  end
endmodule // dfc_host_model

// ==== dfc_pkg.sv ====
// Purpose: Shared constants and types for the disturbance/friction compensation stage
// Assumes: One clock, control cycle marked by a one-cycle enable
// Notes: Register indices are word indices; byte address is four times the index
package dfc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] DFC_IDX_TUNE = 16'h3002;   // Realtime autotuning setting
  localparam logic [15:0] DFC_IDX_UNBAL = 16'h3607;  // Unbalanced-load offset
  localparam logic [15:0] DFC_IDX_POSF = 16'h3608;   // Positive friction offset
  localparam logic [15:0] DFC_IDX_NEGF = 16'h3609;   // Negative friction offset
  localparam logic [15:0] DFC_IDX_FX = 16'h3610;     // Function expansion bits
  localparam logic [15:0] DFC_IDX_GAIN = 16'h3623;   // Observer gain
  localparam logic [15:0] DFC_IDX_FILT = 16'h3624;   // Observer filter time
  localparam logic [15:0] DFC_IDX_STAT = 16'h3700;   // Status, read only
  localparam logic [15:0] DFC_REG_RST = 16'h0000;    // Reset value of all registers
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned DFC_FX_ISO = 0;       // Speed observer enable
  localparam int unsigned DFC_FX_DOB_EN = 1;    // Disturbance observer enable
  localparam int unsigned DFC_FX_G1_ONLY = 2;   // Apply only with gain set 1
  localparam int unsigned DFC_ST_DOB = 0;       // Status: observer active
  localparam int unsigned DFC_ST_HOLD = 1;      // Status: holding for first command
  localparam int unsigned DFC_ST_APPLY = 2;     // Status: observer output applied
  localparam int unsigned DFC_GAIN_FRAC = 8;    // Gain is unsigned, 8 fraction bits
  localparam int unsigned DFC_ACC_FRAC = 16;    // Filter accumulator fraction bits
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    DFC_MODE_POS = 2'b00,
    DFC_MODE_SPD = 2'b01,
    DFC_MODE_FRC = 2'b10,
    DFC_MODE_OTH = 2'b11
  } dfc_mode_t;
  typedef enum logic [1:0] {
    DFC_PC_IDLE = 2'b00,
    DFC_PC_HOLD = 2'b01,
    DFC_PC_RUN = 2'b10
  } dfc_pc_t;
  typedef struct packed {
    dfc_mode_t mode;      // Active control mode
    logic servo_on;       // Servo energised
    logic pole_est_busy;  // Pole position estimation running
    logic gain1_sel;      // First gain set selected
  } dfc_drive_t;
  typedef struct packed {
    logic [15:0] tune;
    logic [15:0] unbal;
    logic [15:0] posf;
    logic [15:0] negf;
    logic [15:0] fx;
    logic [15:0] gain;
    logic [15:0] filt;
  } dfc_cfg_t;
  // Word index match against a byte address
  function automatic logic dfc_hit(input logic [15:0] addr, input logic [15:0] idx);
    return addr == {idx[13:0], 2'b00};
  endfunction
  // Clamp a wide signed value into 16 bits
  function automatic logic signed [15:0] dfc_sat(input logic signed [35:0] v);
    if (v > 36'sd32767) return 16'sh7FFF;
    if (v < -36'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction
endpackage

// ==== tb.sv ====
// Purpose: Self-checking bench for the compensation stage
// Assumes: APB answers within a bounded wait
// Notes: Expected offsets follow the mode rules
`timescale 1ns/10ps
module tb;
  import dfc_pkg::*;
  logic clk_sys = 1'b0; // Clock
  logic srst = 1'b1; // Reset, held at start
  logic cmd_req = 1'b0; // Command request
  logic signed [31:0] cmd_amt = 32'sh0; // Command amount
  dfc_drive_t drive_st = '0; // Mode and servo
  logic signed [15:0] force_in = 16'sh0; // Force in
  logic signed [15:0] dist_est = 16'sh0; // Disturbance estimate
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [15:0] paddr = 16'h0000; // APB address
  logic [31:0] pwdata = 32'h0, prdata, rd; // APB data
  logic pready, pslverr, ctrl_ce, pcmd_valid, dob_active, er; // Status
  logic signed [31:0] pcmd_delta; // Command amount
  logic signed [15:0] force_out, unbal_comp, fric_comp; // Results
  int errors = 0;
  int checks = 0;
  localparam logic [15:0] RIDX [7] = '{DFC_IDX_TUNE, DFC_IDX_UNBAL, DFC_IDX_POSF, DFC_IDX_NEGF,
    DFC_IDX_FX, DFC_IDX_GAIN, DFC_IDX_FILT}; // Writable registers
  always #5 clk_sys = ~clk_sys;
  dfc_host_model i_dfc_host_model (.clk_sys(clk_sys), .srst(srst), .cmd_req(cmd_req), .cmd_amt(cmd_amt),
    .ctrl_ce(ctrl_ce), .pcmd_valid(pcmd_valid), .pcmd_delta(pcmd_delta));
  dfc_comp_top i_dfc_comp_top (.clk_sys(clk_sys), .srst(srst), .ctrl_ce(ctrl_ce), .drive_st(drive_st),
    .pcmd_valid(pcmd_valid), .pcmd_delta(pcmd_delta), .force_in(force_in), .dist_est(dist_est),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .force_out(force_out), .unbal_comp(unbal_comp),
    .fric_comp(fric_comp), .dob_active(dob_active));
  // ************
  // Tasks
  // ************
  task automatic give_verdict;
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic signed [31:0] e, input logic signed [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Whole APB transfer; answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic sd(input dfc_mode_t m, input logic s, input logic b, input logic g);
    @(posedge clk_sys);
    drive_st <= '{mode: m, servo_on: s, pole_est_busy: b, gain1_sel: g};
  endtask
  task automatic cmd(input int a);
    @(posedge clk_sys);
    cmd_amt <= a;
    cmd_req <= 1'b1;
    @(posedge clk_sys);
    cmd_req <= 1'b0;
  endtask
  // Offsets in use and the resulting force after a few control cycles
  task automatic cc(input int u, input int f, input int fo);
    run(12);
    chk("unbal_comp", u, unbal_comp);
    chk("fric_comp", f, fric_comp);
    chk("force_out", fo, force_out);
  endtask
  // Observer gating case in speed mode; d of 2 skips the active flag
  task automatic obs(input logic [15:0] tn, input logic [15:0] fx, input logic b, input logic s,
    input logic g, input int d, input int fo);
    apb(1'b1, DFC_IDX_TUNE, {16'h0, tn});
    apb(1'b1, DFC_IDX_FX, {16'h0, fx});
    sd(DFC_MODE_SPD, s, b, g);
    run(24);
    if (d < 2) chk("dob_active", d, {31'h0, dob_active});
    chk("force_out", fo, force_out);
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rdc(RIDX[i], 32'h0);
      apb(1'b1, RIDX[i], 32'hABCD_0000 | 32'(i + 1) * 32'h11);
      rdc(RIDX[i], 32'(i + 1) * 32'h11);
    end
    apb(1'b0, 16'h0001, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    chk("prdata", 32'h0, rd);
    apb(1'b1, DFC_IDX_TUNE, 32'h0);
    apb(1'b1, DFC_IDX_FX, 32'h0);
    apb(1'b1, DFC_IDX_UNBAL, 32'd10);
    apb(1'b1, DFC_IDX_POSF, 32'd20);
    apb(1'b1, DFC_IDX_NEGF, 32'h0000_FFE2);
    force_in <= 16'sd1000;
    sd(DFC_MODE_POS, 1'b1, 1'b0, 1'b0);
    cmd(5);
    cc(10, 20, 1030);
    apb(1'b1, DFC_IDX_POSF, 32'd40);
    cmd(0);
    cc(10, 20, 1030);
    cmd(-3);
    cc(10, -30, 980);
    apb(1'b1, DFC_IDX_UNBAL, 32'd50);
    sd(DFC_MODE_POS, 1'b0, 1'b0, 1'b0);
    run(8);
    sd(DFC_MODE_POS, 1'b1, 1'b0, 1'b0);
    rdc(DFC_IDX_STAT, 32'h2);
    cc(10, -30, 980);
    cmd(1);
    cc(50, 40, 1090);
    sd(DFC_MODE_SPD, 1'b0, 1'b0, 1'b0);
    cc(50, 0, 1050);
    sd(DFC_MODE_FRC, 1'b1, 1'b0, 1'b0);
    cc(0, 0, 1000);
    sd(DFC_MODE_OTH, 1'b1, 1'b0, 1'b0);
    cc(50, 0, 1050);
    apb(1'b1, DFC_IDX_UNBAL, 32'h0);
    apb(1'b1, DFC_IDX_GAIN, 32'h200);
    apb(1'b1, DFC_IDX_FILT, 32'h0);
    force_in <= 16'sh0;
    dist_est <= 16'sd100;
    obs(16'h0, 16'h2, 1'b0, 1'b1, 1'b0, 1, -200);
    rdc(DFC_IDX_STAT, 32'h5);
    obs(16'h1, 16'h2, 1'b0, 1'b1, 1'b0, 0, 0);
    obs(16'h0, 16'h3, 1'b0, 1'b1, 1'b0, 0, 0);
    obs(16'h0, 16'h2, 1'b1, 1'b1, 1'b0, 0, 0);
    obs(16'h0, 16'h2, 1'b0, 1'b0, 1'b0, 0, 0);
    obs(16'h0, 16'h0, 1'b0, 1'b1, 1'b0, 0, 0);
    apb(1'b1, DFC_IDX_FILT, 32'h8000);
    obs(16'h0, 16'h2, 1'b0, 1'b1, 1'b0, 1, 0);
    apb(1'b1, DFC_IDX_FILT, 32'h0);
    obs(16'h0, 16'h6, 1'b0, 1'b1, 1'b0, 1, 0);
    obs(16'h0, 16'h6, 1'b0, 1'b1, 1'b1, 1, -200);
    give_verdict();
  end
  // Watchdog against a hang anywhere in the sequence
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end
endmodule // tb
